// ===== rtl/devcfg_consts.svh
// Constants for the device configuration register block.
`ifndef DEVCFG_CONSTS_SVH
`define DEVCFG_CONSTS_SVH
`define CFG_ADDR 8'h10
`define CFG_BIT_FORCE_HARD_RESET 7
`define CFG_BIT_ALIVE_COUNTER 6
`define CFG_BIT_ALU_TEST 5
`define CFG_BIT_SCAN_WD_DISABLE 4
`define CFG_BIT_DOUBLE_BUFFER 3
`define CFG_BIT_PACKET_CHECK_DIS 2
`define CFG_BIT_ADDR_UNLOCK 1
`define CFG_BIT_SOFT_RESET 0
`define CFG_RESET_VALUE 16'h0002
`define CFG_WRITE_MASK 16'hF8FC
`define DEVADDR_RESET 5'h00
`endif

// ===== rtl/devcfg_pkg.sv
// Types shared by the device configuration block.
package devcfg_pkg;
	typedef logic [15:0] cfg_word_t;
	typedef enum logic [0:0] {
		HOLD = 1'b0,
		PULL = 1'b1
	} pull_state_t;
endpackage : devcfg_pkg

// ===== rtl/result_mux.sv
// Selects ALU input and times the result copy.
`timescale 1ns/1ps
module result_mux #(
	parameter int DATA_W = 12
) (
	// Clock and reset
	input wire logic mclk,
	input wire logic arst_n,
	// Mode controls
	input wire logic alu_test_enable,
	input wire logic double_buffer_enable,
	// Data sources
	input wire logic [DATA_W-1:0] converter_data,
	input wire logic [DATA_W-1:0] alu_test_data,
	// Acquisition events
	input wire logic acq_start,
	input wire logic acq_end,
	// Outputs
	output logic [DATA_W-1:0] alu_input,
	output logic result_copy
);
	logic [DATA_W-1:0] next_alu_input;
	logic next_result_copy;

	always_comb begin
		next_alu_input = alu_test_enable ? alu_test_data : converter_data;
		// Double buffering defers the copy so the host can still read old results.
		next_result_copy = double_buffer_enable ? acq_start : acq_end;
	end

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			alu_input <= '0;
			result_copy <= 1'b0;
		end else begin
			alu_input <= next_alu_input;
			result_copy <= next_result_copy;
		end
	end
endmodule : result_mux

// ===== rtl/device_config_register.sv
// Device configuration register and its control outputs.
`timescale 1ns/1ps
`include "devcfg_consts.svh"

// Function
// - Force-hard-reset bit pulls shutdown pin low internally; resets to zero.
// - Clearing force-hard-reset before reset takes effect releases the pull-down.
// - Alive-counter enable adds an alive byte to every packet.
// - ALU test enable feeds 12-bit test data instead of converter results.
// - Watchdog disable stops watchdog but keeps a set timeout flag.
// - Double-buffer mode copies results at next acquisition start.
// - Packet-check disable turns off error checking; resets to zero.
// - Address unlock resets to one and allows device address writes.
// - Only the enumeration broadcast clears address unlock; writes cannot.
// - Writing one to soft reset request triggers soft reset; zero ignored.
// - Soft reset request always reads back zero.
// - Register sits at address 0x10.
module device_config_register #(
	parameter int DATA_W = 12
) (
	// Clock and reset
	input wire logic mclk,
	input wire logic arst_n,
	// Register access from packet decoder
	input wire logic [7:0] reg_addr,
	input wire logic reg_write,
	input wire logic [15:0] reg_wdata,
	output logic [15:0] reg_rdata,
	// Enumeration
	input wire logic enumeration_broadcast,
	input wire logic addr_write,
	input wire logic [4:0] addr_wdata,
	output logic [4:0] device_address,
	// Reset control
	input wire logic hard_reset_taken,
	output logic shutdown_pin_n_o,
	output logic shutdown_pin_n_oe,
	output logic soft_reset_pulse,
	// Link options
	output logic alive_counter_enable,
	output logic packet_check_enable,
	// Acquisition
	input wire logic scan_timeout_event,
	input wire logic scan_timeout_clear,
	output logic scan_timeout_flag,
	output logic watchdog_run,
	input wire logic [DATA_W-1:0] converter_data,
	input wire logic [DATA_W-1:0] alu_test_data,
	input wire logic acq_start,
	input wire logic acq_end,
	output logic [DATA_W-1:0] alu_input,
	output logic result_copy
);
	// The mask is held as a sized constant so single bits can be picked.
	// Unlock and soft-reset bits and bits 10:8 lie outside it.
	localparam logic [15:0] WRITE_MASK = `CFG_WRITE_MASK;

	devcfg_pkg::cfg_word_t cfg;
	devcfg_pkg::cfg_word_t next_cfg;
	devcfg_pkg::cfg_word_t merged_word;
	devcfg_pkg::pull_state_t pull;
	devcfg_pkg::pull_state_t next_pull;
	logic [4:0] next_device_address;
	logic next_soft_reset_pulse;
	logic next_scan_timeout_flag;
	logic [15:0] next_reg_rdata;
	logic hit;
	logic hard_reset_meta;
	logic hard_reset_sync;

	// ************************************************************
	// Hard reset indication synchroniser
	// ************************************************************
	// The chip reset status comes from outside this clock domain, so
	// only the second flop is read by the pull-down logic.
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			hard_reset_meta <= 1'b0;
			hard_reset_sync <= 1'b0;
		end else begin
			hard_reset_meta <= hard_reset_taken;
			hard_reset_sync <= hard_reset_meta;
		end
	end

	// ************************************************************
	// Write merge
	// ************************************************************
	// Each bit outside the mask keeps its stored value on a write, so
	// reserved bits cannot be set by a careless host.
	for (genvar b = 0; b < 16; b++) begin : g_merge
		assign merged_word[b] = WRITE_MASK[b] ? reg_wdata[b] : cfg[b];
	end

	// ************************************************************
	// Configuration word
	// ************************************************************
	// Soft reset is only a strobe; the stored bit never holds a one.
	always_comb begin
		hit = reg_write && (reg_addr == `CFG_ADDR);
		next_cfg = cfg;
		if (hit) begin
			next_cfg = merged_word;
		end
		if (enumeration_broadcast) begin
			next_cfg[`CFG_BIT_ADDR_UNLOCK] = 1'b0;
		end
		next_cfg[`CFG_BIT_SOFT_RESET] = 1'b0;
		next_soft_reset_pulse = hit && reg_wdata[`CFG_BIT_SOFT_RESET];
		next_reg_rdata = next_cfg;
	end

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			cfg <= `CFG_RESET_VALUE;
			soft_reset_pulse <= 1'b0;
			reg_rdata <= `CFG_RESET_VALUE;
		end else begin
			cfg <= next_cfg;
			soft_reset_pulse <= next_soft_reset_pulse;
			reg_rdata <= next_reg_rdata;
		end
	end

	// ************************************************************
	// Device address
	// ************************************************************
	// Once locked, address writes are dropped silently; only a reset
	// of the block unlocks the address again.
	always_comb begin
		next_device_address = device_address;
		if (addr_write && cfg[`CFG_BIT_ADDR_UNLOCK]) begin
			next_device_address = addr_wdata;
		end
	end

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			device_address <= `DEVADDR_RESET;
		end else begin
			device_address <= next_device_address;
		end
	end

	// ************************************************************
	// Shutdown pull-down
	// ************************************************************
	// Clearing the bit before the chip reset lands drops the pull-down,
	// so a mistaken request can still be withdrawn.
	always_comb begin
		next_pull = pull;
		unique case (pull)
			devcfg_pkg::HOLD: begin
				if (next_cfg[`CFG_BIT_FORCE_HARD_RESET]) begin
					next_pull = devcfg_pkg::PULL;
				end
			end
			devcfg_pkg::PULL: begin
				if (!next_cfg[`CFG_BIT_FORCE_HARD_RESET]) begin
					next_pull = devcfg_pkg::HOLD;
				end
			end
		endcase
	end

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			pull <= devcfg_pkg::HOLD;
		end else begin
			pull <= next_pull;
		end
	end

	// ************************************************************
	// Scan timeout flag
	// ************************************************************
	always_comb begin
		// An event in the clear cycle wins while the watchdog runs; disabling never clears the flag.
		next_scan_timeout_flag = scan_timeout_flag;
		if (scan_timeout_clear) begin
			next_scan_timeout_flag = 1'b0;
		end
		if (scan_timeout_event && !cfg[`CFG_BIT_SCAN_WD_DISABLE]) begin
			next_scan_timeout_flag = 1'b1;
		end
	end

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			scan_timeout_flag <= 1'b0;
		end else begin
			scan_timeout_flag <= next_scan_timeout_flag;
		end
	end

	// ************************************************************
	// Control outputs
	// ************************************************************
	// The pull-down drives low only; hard_reset_taken is the chip reset.
	assign shutdown_pin_n_o = 1'b0;
	assign shutdown_pin_n_oe = (pull == devcfg_pkg::PULL)
		&& !hard_reset_sync;
	assign alive_counter_enable = cfg[`CFG_BIT_ALIVE_COUNTER];
	assign packet_check_enable = !cfg[`CFG_BIT_PACKET_CHECK_DIS];
	assign watchdog_run = !cfg[`CFG_BIT_SCAN_WD_DISABLE];

	result_mux #(
		.DATA_W(DATA_W)
	) u_result_mux (
		.mclk(mclk),
		.arst_n(arst_n),
		.alu_test_enable(cfg[`CFG_BIT_ALU_TEST]),
		.double_buffer_enable(cfg[`CFG_BIT_DOUBLE_BUFFER]),
		.converter_data(converter_data),
		.alu_test_data(alu_test_data),
		.acq_start(acq_start),
		.acq_end(acq_end),
		.alu_input(alu_input),
		.result_copy(result_copy)
	);
endmodule : device_config_register

// ===== tb/host_model.sv
// Stand-in for the packet decoder that issues register writes.
`timescale 1ns/1ps
module host_model (
	// Clock
	input wire logic mclk,
	// Register write side
	output logic [7:0] reg_addr,
	output logic reg_write,
	output logic [15:0] reg_wdata
);
	initial begin
		reg_addr = 8'h00;
		reg_write = 1'b0;
		reg_wdata = 16'h0000;
	end
	// Released data is inverted so a stale word never looks like a new one.
	task wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge mclk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_write <= 1'b1;
		@(posedge mclk);
		reg_write <= 1'b0;
		reg_wdata <= ~d;
	endtask : wr
endmodule : host_model

// ===== tb/devcfg_asserts.sv
// Concurrent checks on the configuration register block.
`timescale 1ns/1ps
module devcfg_asserts (
	// Clock and reset
	input wire logic mclk,
	input wire logic arst_n,
	// Register access
	input wire logic reg_write,
	input wire logic [7:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic [15:0] reg_rdata,
	// Address and reset control
	input wire logic addr_write,
	input wire logic [4:0] addr_wdata,
	input wire logic [4:0] device_address,
	input wire logic hard_reset_taken,
	// Outputs under watch
	input wire logic shutdown_pin_n_o,
	input wire logic shutdown_pin_n_oe,
	input wire logic soft_reset_pulse,
	input wire logic alive_counter_enable,
	input wire logic packet_check_enable,
	input wire logic watchdog_run,
	input wire logic scan_timeout_clear,
	input wire logic scan_timeout_flag,
	input wire logic acq_start,
	input wire logic result_copy
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!arst_n);
	sequence s_wr; reg_write && reg_addr == 8'h10; endsequence
	property p_rsvd; reg_rdata[10:8] == 3'h0 && !reg_rdata[0]; endproperty
	a_rsvd: assert property (p_rsvd) else $error("reserved bit set");
	property p_keep; !$rose(reg_rdata[1]); endproperty
	a_keep: assert property (p_keep) else $error("unlock rose");
	property p_addr;
		$changed(device_address) |-> $past(addr_write) &&
			device_address == $past(addr_wdata);
	endproperty
	a_addr: assert property (p_addr) else $error("address bad");
	property p_pull;
		$rose(reg_rdata[7]) && !hard_reset_taken |->
			shutdown_pin_n_oe && !shutdown_pin_n_o;
	endproperty
	a_pull: assert property (p_pull) else $error("no pull");
	property p_rel; !reg_rdata[7] |-> !shutdown_pin_n_oe; endproperty
	a_rel: assert property (p_rel) else $error("pull held");
	// Mode outputs and the readback both come from the stored word.
	property p_mode;
		reg_rdata[6] == alive_counter_enable &&
			reg_rdata[2] != packet_check_enable &&
			reg_rdata[4] != watchdog_run;
	endproperty
	a_mode: assert property (p_mode) else $error("mode bad");
	property p_dbl; acq_start ##1 reg_rdata[3] |-> result_copy; endproperty
	a_dbl: assert property (p_dbl) else $error("no copy");
	property p_soft_reset_request; s_wr ##0 reg_wdata[0] |-> ##[1:2] soft_reset_pulse; endproperty
	a_soft_reset_request: assert property (p_soft_reset_request) else $error("no soft reset");
	// The chip reset status passes two flops before it drops the pull.
	property p_hrst; hard_reset_taken [*3] |-> !shutdown_pin_n_oe; endproperty
	a_hrst: assert property (p_hrst) else $error("pull kept");
	property p_sticky;
		scan_timeout_flag && !scan_timeout_clear |=> scan_timeout_flag;
	endproperty
	a_sticky: assert property (p_sticky) else $error("flag lost");
endmodule : devcfg_asserts
bind device_config_register devcfg_asserts i_devcfg_asserts (.*);

// ===== tb/testbench.sv
// Self-checking bench for the configuration register block.
`timescale 1ns/1ps
module testbench;
	logic mclk, arst_n, enumeration_broadcast, addr_write, hard_reset_taken;
	logic scan_timeout_event, scan_timeout_clear, acq_start, acq_end;
	logic reg_write, shutdown_pin_n_o, shutdown_pin_n_oe, soft_reset_pulse;
	logic alive_counter_enable, packet_check_enable, scan_timeout_flag;
	logic watchdog_run, result_copy;
	logic [7:0] reg_addr;
	logic [15:0] reg_wdata, reg_rdata;
	logic [4:0] addr_wdata, device_address;
	logic [11:0] converter_data, alu_test_data, alu_input;
	int err_count, compares, cycles;
	host_model i_host_model (.mclk, .reg_addr, .reg_write, .reg_wdata);
	device_config_register i_device_config_register (.*);
	initial begin
		mclk = 1'b0;
		forever #2.5 mclk = ~mclk;
	end
	task cmp(input logic [15:0] got, input logic [15:0] exp);
		compares++;
		if (got !== exp) begin
			err_count++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : cmp
	task tw;
		repeat (2) @(posedge mclk);
		#1;
	endtask : tw
	task test_done;
		$display("compares=%0d err_count=%0d", compares, err_count);
		if (err_count == 0 && compares > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask : test_done
	// The whole run needs under two hundred cycles.
	always @(posedge mclk) begin
		cycles++;
		if (cycles == 500) begin
			err_count++;
			test_done();
		end
	end
	initial begin
		{arst_n, enumeration_broadcast, addr_write, hard_reset_taken} = 4'h0;
		{scan_timeout_event, scan_timeout_clear, acq_start, acq_end} = 4'h0;
		addr_wdata = 5'h00;
		converter_data = 12'h5a5;
		alu_test_data = 12'ha3c;
		repeat (10) @(posedge mclk);
		arst_n <= 1'b1;
		tw();
		cmp(reg_rdata, 16'h0002);
		cmp({packet_check_enable, watchdog_run}, 16'h0003);
		i_host_model.wr(8'h10, 16'hffff);
		#1;
		cmp(soft_reset_pulse, 16'h0001);
		tw();
		cmp(soft_reset_pulse, 16'h0000);
		cmp(reg_rdata, 16'hf8fe);
		cmp({shutdown_pin_n_oe, shutdown_pin_n_o, alive_counter_enable,
			packet_check_enable, watchdog_run}, 16'h0014);
		@(posedge mclk);
		hard_reset_taken <= 1'b1;
		repeat (3) @(posedge mclk);
		#1;
		cmp(shutdown_pin_n_oe, 16'h0000);
		@(posedge mclk);
		hard_reset_taken <= 1'b0;
		i_host_model.wr(8'h11, 16'h0000);
		tw();
		cmp(reg_rdata, 16'hf8fe);
		i_host_model.wr(8'h10, 16'h0020);
		#1;
		cmp(soft_reset_pulse, 16'h0000);
		tw();
		cmp(alu_input, alu_test_data);
		cmp(shutdown_pin_n_oe, 16'h0000);
		i_host_model.wr(8'h10, 16'h0008);
		tw();
		cmp(alu_input, converter_data);
		@(posedge mclk);
		acq_start <= 1'b1;
		@(posedge mclk);
		acq_start <= 1'b0;
		acq_end <= 1'b1;
		#1;
		cmp(result_copy, 16'h0001);
		@(posedge mclk);
		acq_end <= 1'b0;
		#1;
		cmp(result_copy, 16'h0000);
		@(posedge mclk);
		scan_timeout_event <= 1'b1;
		scan_timeout_clear <= 1'b1;
		@(posedge mclk);
		scan_timeout_event <= 1'b0;
		scan_timeout_clear <= 1'b0;
		#1;
		cmp(scan_timeout_flag, 16'h0001);
		i_host_model.wr(8'h10, 16'h0018);
		tw();
		cmp({scan_timeout_flag, watchdog_run}, 16'h0002);
		@(posedge mclk);
		scan_timeout_event <= 1'b1;
		scan_timeout_clear <= 1'b1;
		@(posedge mclk);
		scan_timeout_event <= 1'b0;
		scan_timeout_clear <= 1'b0;
		#1;
		cmp(scan_timeout_flag, 16'h0000);
		i_host_model.wr(8'h10, 16'h0040);
		tw();
		cmp({alive_counter_enable, watchdog_run}, 16'h0003);
		@(posedge mclk);
		acq_start <= 1'b1;
		@(posedge mclk);
		acq_start <= 1'b0;
		acq_end <= 1'b1;
		#1;
		cmp(result_copy, 16'h0000);
		@(posedge mclk);
		acq_end <= 1'b0;
		#1;
		cmp(result_copy, 16'h0001);
		i_host_model.wr(8'h10, 16'h0008);
		tw();
		@(posedge mclk);
		addr_wdata <= 5'h15;
		addr_write <= 1'b1;
		@(posedge mclk);
		addr_write <= 1'b0;
		enumeration_broadcast <= 1'b1;
		@(posedge mclk);
		enumeration_broadcast <= 1'b0;
		tw();
		cmp(device_address, 16'h0015);
		cmp(reg_rdata, 16'h0008);
		i_host_model.wr(8'h10, 16'h0002);
		@(posedge mclk);
		addr_wdata <= 5'h0a;
		addr_write <= 1'b1;
		@(posedge mclk);
		addr_write <= 1'b0;
		tw();
		cmp(reg_rdata, 16'h0000);
		cmp(device_address, 16'h0015);
		test_done();
	end
endmodule : testbench
